// ---- hw/can_ctl0_defs.svh ----
// Register offsets, bit positions and timing counts of the CAN control block
`ifndef CAN_CTL0_DEFS_SVH
`define CAN_CTL0_DEFS_SVH

// Register byte addresses on the APB port
`define CTL0_ADDR        12'h000
`define MODE_STAT_ADDR   12'h004
`define STAMP_ADDR       12'h008

// Bit positions in can_control_zero
`define FRAME_FLAG_BIT   7
`define RX_ACTIVE_BIT    6
`define STOP_WAIT_BIT    5
`define BUS_SYNC_BIT     4
`define STAMP_EN_BIT     3
`define WAKE_EN_BIT      2
`define SLEEP_REQ_BIT    1
`define INIT_REQ_BIT     0

// Bit positions in the mode status register
`define INIT_ACK_BIT     1
`define SLEEP_ACK_BIT    0

// Reset value of can_control_zero
`define CTL0_RESET       8'h00

// Recessive bits needed before taking part in bus traffic
`define SYNC_RECESSIVE_BITS  4'hB

// Timing: clock period and nominal CAN bit time
`define CLK_PERIOD_NS    4
`define BIT_TIME_NS      1000
`define BIT_CYCLES       (`BIT_TIME_NS / `CLK_PERIOD_NS)

`endif

// ---- hw/can_ctl0_pkg.sv ----
// Types shared by the CAN control block
package can_ctl0_pkg;

   typedef enum logic {
      pw_run,
      pw_sleep
   } power_state_t;

   typedef logic [15:0] stamp_t;

endpackage : can_ctl0_pkg

// ---- hw/can_ctl0_top.sv ----
// CAN first control register: status, timestamp, sleep and wake-up logic behind APB
`timescale 1ns/1ps
`default_nettype none
`include "can_ctl0_defs.svh"

module can_ctl0_top
   import can_ctl0_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        bus_receive_pin,
   output logic             bus_transmit_pin,
   input  wire logic        engine_tx_bit,
   input  wire logic        rx_busy_in,
   input  wire logic        tx_busy_in,
   input  wire logic        eof_valid_in,
   input  wire logic        eof_is_rx_in,
   input  wire logic        loopback_in,
   input  wire logic        cpu_wait_mode,
   input  wire logic        cpu_stop_mode,
   output logic             can_rx_internal,
   output logic             bus_clock_enable,
   output logic             abort_activity,
   output logic             stamp_write,
   output logic      [15:0] stamp_value,
   output logic             wakeup_event
);

   ////////////////////////////////////////////////////////////////////////////////
   // Decode

   function automatic logic is_mapped(input logic [11:0] addr);
      is_mapped = (addr == `CTL0_ADDR) || (addr == `MODE_STAT_ADDR) ||
                  (addr == `STAMP_ADDR);
   endfunction : is_mapped

   ////////////////////////////////////////////////////////////////////////////////
   // State

   logic         frame_flag_r,  frame_flag_nxt;
   logic         stop_wait_r,   stop_wait_nxt;
   logic         stamp_en_r,    stamp_en_nxt;
   logic         wake_en_r,     wake_en_nxt;
   logic         sleep_req_r,   sleep_req_nxt;
   logic         init_req_r,    init_req_nxt;
   logic         init_ack_r,    init_ack_nxt;
   logic         wake_lat_r,    wake_lat_nxt;
   logic         in_sync_r,     in_sync_nxt;
   logic [3:0]   rec_cnt_r,     rec_cnt_nxt;
   logic [7:0]   tick_cnt_r,    tick_cnt_nxt;
   logic         pd_r,          pd_nxt;
   power_state_t pw_state_r,    pw_state_nxt;

   logic         receiver_active_r,       receiver_active_nxt;
   logic         tx_pin_r,      tx_pin_nxt;
   logic         clk_en_r,      clk_en_nxt;
   logic         abort_r,       abort_nxt;
   logic         stamp_wr_r,    stamp_wr_nxt;
   stamp_t       stamp_val_r,   stamp_val_nxt;
   logic         rx_int_r,      rx_int_nxt;
   logic         wake_r,        wake_nxt;
   logic [31:0]  prdata_r,      prdata_nxt;
   logic         pready_r,      pready_nxt;
   logic         pslverr_r,     pslverr_nxt;

   logic         rx_sync;
   stamp_t       stamp_count;
   logic         bit_tick;
   logic         init_mode;
   logic         power_down;
   logic         wr_ctl;
   logic         rx_masked;
   logic [7:0]   ctl0_view;

   ////////////////////////////////////////////////////////////////////////////////
   // Submodules

   sync2 u_rx_sync (
      .clk      (pclk),
      .rst_n    (presetn),
      .async_in (bus_receive_pin),
      .sync_out (rx_sync)
   );

   stamp_counter u_stamp (
      .clk      (pclk),
      .rst_n    (presetn),
      .enable   (stamp_en_r),
      .bit_tick (bit_tick),
      .count    (stamp_count)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Combinational helpers

   assign bit_tick   = (tick_cnt_r == 8'(`BIT_CYCLES - 1));
   assign init_mode  = init_req_r & init_ack_r;
   assign power_down = cpu_stop_mode | (cpu_wait_mode & stop_wait_r);
   assign wr_ctl     = psel & penable & pready_r & pwrite & ~pslverr_r &
                       (paddr == `CTL0_ADDR);
   // Asleep without wake-up the bus is masked to recessive
   assign rx_masked  = ((pw_state_r == pw_sleep) && !wake_lat_r) ? 1'b1 : rx_sync;
   assign ctl0_view  = {frame_flag_r, receiver_active_r, stop_wait_r, in_sync_r,
                        stamp_en_r, wake_en_r, sleep_req_r, init_req_r};

   ////////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      frame_flag_nxt = frame_flag_r;
      stop_wait_nxt  = stop_wait_r;
      stamp_en_nxt   = stamp_en_r;
      wake_en_nxt    = wake_en_r;
      sleep_req_nxt  = sleep_req_r;
      init_req_nxt   = init_req_r;
      init_ack_nxt   = init_req_r;
      wake_lat_nxt   = wake_lat_r;
      in_sync_nxt    = in_sync_r;
      rec_cnt_nxt    = rec_cnt_r;
      pw_state_nxt   = pw_state_r;
      wake_nxt       = 1'b0;
      tick_cnt_nxt   = bit_tick ? 8'h00 : tick_cnt_r + 8'h01;
      pd_nxt         = power_down;

      // Set wins over a clearing write
      if (wr_ctl && pwdata[`FRAME_FLAG_BIT]) begin
         frame_flag_nxt = 1'b0;
      end
      if (eof_valid_in && eof_is_rx_in && !loopback_in) begin
         frame_flag_nxt = 1'b1;
      end

      if (wr_ctl) begin
         stop_wait_nxt = pwdata[`STOP_WAIT_BIT];
         stamp_en_nxt  = pwdata[`STAMP_EN_BIT];
         wake_en_nxt   = pwdata[`WAKE_EN_BIT];
         init_req_nxt  = pwdata[`INIT_REQ_BIT];
         if (pwdata[`SLEEP_REQ_BIT]) begin
            sleep_req_nxt = 1'b1;
         end else if (sleep_req_r && pw_state_r == pw_sleep) begin
            sleep_req_nxt = 1'b0;
         end
      end

      if (init_mode) begin
         frame_flag_nxt = 1'b0;
         stop_wait_nxt  = 1'b0;
         stamp_en_nxt   = 1'b0;
      end

      case (pw_state_r)
         pw_run: begin
            if (sleep_req_r && !rx_busy_in && !tx_busy_in) begin
               pw_state_nxt = pw_sleep;
               wake_lat_nxt = wake_en_r;
            end
         end
         pw_sleep: begin
            if (wake_lat_r && !rx_sync) begin
               pw_state_nxt  = pw_run;
               sleep_req_nxt = 1'b0;
               wake_nxt      = 1'b1;
            end else if (!sleep_req_nxt) begin
               pw_state_nxt = pw_run;
            end
         end
         default: begin
            pw_state_nxt = pw_run;
         end
      endcase

      // Synchronize only after a run of recessive bits
      if (pw_state_r == pw_sleep || init_mode || power_down) begin
         in_sync_nxt = 1'b0;
         rec_cnt_nxt = 4'h0;
      end else if (!in_sync_r && bit_tick) begin
         if (rx_masked) begin
            rec_cnt_nxt = rec_cnt_r + 4'h1;
            if (rec_cnt_r == `SYNC_RECESSIVE_BITS - 4'h1) begin
               in_sync_nxt = 1'b1;
            end
         end else begin
            rec_cnt_nxt = 4'h0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_flag_r <= 1'b0;
         stop_wait_r  <= 1'b0;
         stamp_en_r   <= 1'b0;
         wake_en_r    <= 1'b0;
         sleep_req_r  <= 1'b0;
         init_req_r   <= 1'b0;
         init_ack_r   <= 1'b0;
         wake_lat_r   <= 1'b0;
         in_sync_r    <= 1'b0;
         rec_cnt_r    <= 4'h0;
         tick_cnt_r   <= 8'h00;
         pd_r         <= 1'b0;
         pw_state_r   <= pw_run;
         wake_r       <= 1'b0;
      end else begin
         frame_flag_r <= frame_flag_nxt;
         stop_wait_r  <= stop_wait_nxt;
         stamp_en_r   <= stamp_en_nxt;
         wake_en_r    <= wake_en_nxt;
         sleep_req_r  <= sleep_req_nxt;
         init_req_r   <= init_req_nxt;
         init_ack_r   <= init_ack_nxt;
         wake_lat_r   <= wake_lat_nxt;
         in_sync_r    <= in_sync_nxt;
         rec_cnt_r    <= rec_cnt_nxt;
         tick_cnt_r   <= tick_cnt_nxt;
         pd_r         <= pd_nxt;
         pw_state_r   <= pw_state_nxt;
         wake_r       <= wake_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs and APB answer

   always_comb begin
      receiver_active_nxt     = rx_busy_in & ~tx_busy_in & ~power_down & ~init_mode &
                      (pw_state_r == pw_run);
      tx_pin_nxt    = power_down ? 1'b1 : engine_tx_bit;
      abort_nxt     = power_down & ~pd_r;
      clk_en_nxt    = ~(cpu_wait_mode & stop_wait_r);
      stamp_wr_nxt  = eof_valid_in & stamp_en_r & ~(eof_is_rx_in & loopback_in);
      stamp_val_nxt = stamp_wr_nxt ? stamp_count : stamp_val_r;
      rx_int_nxt    = rx_masked;
      pready_nxt    = psel & ~penable;
      pslverr_nxt   = psel & ~penable & (~is_mapped(paddr) | power_down);
      prdata_nxt    = prdata_r;
      if (psel && !penable) begin
         case (paddr)
            `CTL0_ADDR:      prdata_nxt = {24'h000000, ctl0_view};
            `MODE_STAT_ADDR: prdata_nxt = {30'h00000000, init_ack_r,
                                           (pw_state_r == pw_sleep)};
            `STAMP_ADDR:     prdata_nxt = {16'h0000, stamp_count};
            default:         prdata_nxt = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         receiver_active_r     <= 1'b0;
         tx_pin_r    <= 1'b1;
         abort_r     <= 1'b0;
         clk_en_r    <= 1'b1;
         stamp_wr_r  <= 1'b0;
         stamp_val_r <= 16'h0000;
         rx_int_r    <= 1'b1;
         pready_r    <= 1'b0;
         pslverr_r   <= 1'b0;
         prdata_r    <= 32'h00000000;
      end else begin
         receiver_active_r     <= receiver_active_nxt;
         tx_pin_r    <= tx_pin_nxt;
         abort_r     <= abort_nxt;
         clk_en_r    <= clk_en_nxt;
         stamp_wr_r  <= stamp_wr_nxt;
         stamp_val_r <= stamp_val_nxt;
         rx_int_r    <= rx_int_nxt;
         pready_r    <= pready_nxt;
         pslverr_r   <= pslverr_nxt;
         prdata_r    <= prdata_nxt;
      end
   end

   assign prdata           = prdata_r;
   assign pready           = pready_r;
   assign pslverr          = pslverr_r;
   assign bus_transmit_pin = tx_pin_r;
   assign can_rx_internal  = rx_int_r;
   assign bus_clock_enable = clk_en_r;
   assign abort_activity   = abort_r;
   assign stamp_write      = stamp_wr_r;
   assign stamp_value      = stamp_val_r;
   assign wakeup_event     = wake_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions

   property p_frame_set;
      @(posedge pclk) disable iff (!presetn)
      (eof_valid_in && eof_is_rx_in && !loopback_in && !init_mode) |=> frame_flag_r;
   endproperty
   a_frame_set: assert property (p_frame_set) else $error("frame flag not set");

   property p_frame_hold;
      @(posedge pclk) disable iff (!presetn)
      (frame_flag_r && !init_mode && !(wr_ctl && pwdata[`FRAME_FLAG_BIT])) |=> frame_flag_r;
   endproperty
   a_frame_hold: assert property (p_frame_hold) else $error("frame flag lost");

   property p_stamp_clear;
      @(posedge pclk) disable iff (!presetn)
      !stamp_en_r |=> (stamp_count == 16'h0000);
   endproperty
   a_stamp_clear: assert property (p_stamp_clear) else $error("stamp not cleared");

   property p_stamp_init;
      @(posedge pclk) disable iff (!presetn)
      init_mode |=> !stamp_en_r;
   endproperty
   a_stamp_init: assert property (p_stamp_init) else $error("stamp enabled in init");

   property p_rx_mask;
      @(posedge pclk) disable iff (!presetn)
      (pw_state_r == pw_sleep && !wake_lat_r) |=> rx_int_r;
   endproperty
   a_rx_mask: assert property (p_rx_mask) else $error("receive not masked");

   property p_sleep_clear;
      @(posedge pclk) disable iff (!presetn)
      (pw_state_r == pw_run && sleep_req_r && wr_ctl && !pwdata[`SLEEP_REQ_BIT]) |=> sleep_req_r;
   endproperty
   a_sleep_clear: assert property (p_sleep_clear) else $error("early sleep clear");

   property p_tx_recessive;
      @(posedge pclk) disable iff (!presetn)
      power_down |=> (bus_transmit_pin && ($past(pd_r) || abort_activity));
   endproperty
   a_tx_recessive: assert property (p_tx_recessive) else $error("tx not recessive");

   property p_clk_gate;
      @(posedge pclk) disable iff (!presetn)
      (cpu_wait_mode && stop_wait_r) |=> !bus_clock_enable;
   endproperty
   a_clk_gate: assert property (p_clk_gate) else $error("clock not gated");

   property p_bus_synchronized_run;
      @(posedge pclk) disable iff (!presetn)
      $rose(in_sync_r) |-> ($past(rec_cnt_r) == `SYNC_RECESSIVE_BITS - 4'h1);
   endproperty
   a_bus_synchronized_run: assert property (p_bus_synchronized_run) else $error("bus sync too early");

endmodule : can_ctl0_top

`default_nettype wire

// ---- hw/stamp_counter.sv ----
// Free-running 16-bit bit-time stamp counter, cleared while disabled
`timescale 1ns/1ps
`default_nettype none

module stamp_counter
   import can_ctl0_pkg::*;
(
   input  wire logic   clk,
   input  wire logic   rst_n,
   input  wire logic   enable,
   input  wire logic   bit_tick,
   output var stamp_t  count
);

   stamp_t count_r;
   stamp_t count_nxt;

   always_comb begin
      count_nxt = count_r;
      if (!enable) begin
         count_nxt = 16'h0000;
      end else if (bit_tick) begin
         count_nxt = count_r + 16'h0001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= 16'h0000;
      end else begin
         count_r <= count_nxt;
      end
   end

   assign count = count_r;

endmodule : stamp_counter

`default_nettype wire

// ---- hw/sync2.sv ----
// Two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module sync2 (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic async_in,
   output logic      sync_out
);

   logic meta_r;

   // Idles recessive so a reset does not look like bus traffic
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r   <= 1'b1;
         sync_out <= 1'b1;
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule : sync2

`default_nettype wire

// ---- tb/can_bus_node.sv ----
// Far-side CAN node: drives dominant bursts onto a wired-AND bus
`timescale 1ns/1ps
`default_nettype none

module can_bus_node (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       burst_start,
   input  wire logic [7:0] burst_cycles,
   input  wire logic       dut_tx,
   output logic            bus_level
);
   logic [7:0] left_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         left_r <= 8'h00;
      else if (burst_start)
         left_r <= burst_cycles;
      else if (left_r != 8'h00)
         left_r <= left_r - 8'h01;
   end

   // Dominant wins; with nobody driving, the bus floats back recessive
   assign bus_level = (left_r == 8'h00) & dut_tx;
endmodule : can_bus_node

`default_nettype wire

// ---- tb/can_control_sleep_wakeup_test.sv ----
// Self-checking bench of the CAN first control register block
`timescale 1ns/1ps
`default_nettype none
`include "can_ctl0_defs.svh"

module can_control_sleep_wakeup_test;
   typedef struct packed {
      logic        wr;
      logic [11:0] addr;
      logic [7:0]  wdata;
      logic [15:0] mask;
      logic [15:0] rdexp;
      logic        err;
   } row_t;

   logic        pclk = 1'b0;
   logic        presetn, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, err;
   logic        bus_receive_pin, bus_transmit_pin, engine_tx_bit;
   logic        rx_busy_in, tx_busy_in, eof_valid_in, eof_is_rx_in, loopback_in;
   logic        cpu_wait_mode, cpu_stop_mode, can_rx_internal, bus_clock_enable;
   logic        abort_activity, stamp_write, wakeup_event, burst_start;
   logic [15:0] stamp_value;
   logic [7:0]  burst_cycles;
   int          num_errors = 0;
   int          total_checks = 0;
   int          hits;
   row_t        rows [0:11];

   can_ctl0_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .bus_receive_pin, .bus_transmit_pin, .engine_tx_bit, .rx_busy_in,
      .tx_busy_in, .eof_valid_in, .eof_is_rx_in, .loopback_in, .cpu_wait_mode,
      .cpu_stop_mode, .can_rx_internal, .bus_clock_enable, .abort_activity, .stamp_write,
      .stamp_value, .wakeup_event);

   can_bus_node node (.pclk, .presetn, .burst_start, .burst_cycles,
      .dut_tx(bus_transmit_pin), .bus_level(bus_receive_pin));

   always #2 pclk = ~pclk;

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check

   task automatic test_done();
      $display("checks %0d, errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : test_done

   // One APB transfer, entered and left right after a rising edge
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [7:0] data);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= {24'h000000, data};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         num_errors++;
         test_done();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic read_chk(input string what, input logic [11:0] addr,
                           input logic [15:0] mask, input logic [15:0] exp);
      apb(1'b0, addr, 8'h00);
      check(what, rd & {16'h0000, mask}, {16'h0000, exp});
   endtask : read_chk

   task automatic wait_reg(input logic [11:0] addr, input logic [7:0] mask, input logic [7:0] v);
      int n;
      n = 0;
      do begin
         apb(1'b0, addr, 8'h00);
         n++;
      end while ((rd[7:0] & mask) !== v && n < 100);
      check("poll", 32'(n < 100), 32'h1);
      if (n >= 100)
         test_done();
   endtask : wait_reg

   task automatic frame_end(input logic is_rx, input logic exp_sw);
      eof_valid_in <= 1'b1;
      eof_is_rx_in <= is_rx;
      @(posedge pclk);
      eof_valid_in <= 1'b0;
      #1 check("stamp_write", 32'(stamp_write), 32'(exp_sw));
      @(posedge pclk);
      #1 check("stamp_write end", 32'(stamp_write), 32'h0);
      @(posedge pclk);
   endtask : frame_end

   // Starts an optional dominant burst, then counts pulses of abort or wake-up
   task automatic count_pulses(input logic burst, input logic sel, input int n);
      burst_start <= burst;
      burst_cycles <= 8'h1E;
      hits = 0;
      repeat (n) begin
         @(posedge pclk);
         burst_start <= 1'b0;
         #1 hits += sel ? abort_activity : wakeup_event;
      end
      @(posedge pclk);
   endtask : count_pulses

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {presetn, psel, penable, pwrite, rx_busy_in, tx_busy_in, eof_valid_in} = '0;
      {eof_is_rx_in, loopback_in, cpu_wait_mode, cpu_stop_mode, burst_start} = '0;
      engine_tx_bit = 1'b1;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      burst_cycles = 8'h00;
      rows[0] = '{1'b1, 12'h000, 8'h08, 16'h0000, 16'h0000, 1'b0};
      rows[1] = '{1'b0, 12'h000, 8'h00, 16'h00EF, 16'h0008, 1'b0};
      rows[2] = '{1'b1, 12'h000, 8'h00, 16'h0000, 16'h0000, 1'b0};
      rows[3] = '{1'b0, 12'h008, 8'h00, 16'hFFFF, 16'h0000, 1'b0};
      rows[4] = '{1'b1, 12'h000, 8'h24, 16'h0000, 16'h0000, 1'b0};
      rows[5] = '{1'b0, 12'h000, 8'h00, 16'h00EF, 16'h0024, 1'b0};
      rows[6] = '{1'b1, 12'h000, 8'hC0, 16'h0000, 16'h0000, 1'b0};
      rows[7] = '{1'b0, 12'h000, 8'h00, 16'h00EF, 16'h0000, 1'b0};
      rows[8] = '{1'b1, 12'h004, 8'h03, 16'h0000, 16'h0000, 1'b0};
      rows[9] = '{1'b0, 12'h004, 8'h00, 16'h00FF, 16'h0000, 1'b0};
      rows[10] = '{1'b0, 12'h010, 8'h00, 16'h0000, 16'h0000, 1'b1};
      rows[11] = '{1'b1, 12'h010, 8'hFF, 16'h0000, 16'h0000, 1'b1};
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      #1 check("tx pin", 32'(bus_transmit_pin), 32'h1);
      check("rx internal", 32'(can_rx_internal), 32'h1);
      check("clock enable", 32'(bus_clock_enable), 32'h1);
      @(posedge pclk);
      read_chk("ctl0 reset", 12'h000, 16'h00FF, 16'h0000);
      foreach (rows[i]) begin
         apb(rows[i].wr, rows[i].addr, rows[i].wdata);
         check("row data", rd[15:0] & rows[i].mask, rows[i].rdexp);
         check("row error", 32'(err), 32'(rows[i].err));
      end
      repeat (11 * `BIT_CYCLES + 300) @(posedge pclk);
      read_chk("bus sync", 12'h000, 16'h0010, 16'h0010);
      rx_busy_in <= 1'b1;
      @(posedge pclk);
      read_chk("rx active", 12'h000, 16'h0040, 16'h0040);
      tx_busy_in <= 1'b1;
      @(posedge pclk);
      read_chk("rx idle tx", 12'h000, 16'h0040, 16'h0000);
      rx_busy_in <= 1'b0;
      tx_busy_in <= 1'b0;
      // Frames and stamps
      apb(1'b1, 12'h000, 8'h08);
      repeat (600) @(posedge pclk);
      frame_end(1'b1, 1'b1);
      check("stamp value", 32'(stamp_value inside {16'h0002, 16'h0003}), 32'h1);
      read_chk("flag set", 12'h000, 16'h0080, 16'h0080);
      apb(1'b1, 12'h000, 8'h08);
      read_chk("flag kept", 12'h000, 16'h0080, 16'h0080);
      apb(1'b1, 12'h000, 8'h88);
      read_chk("flag cleared", 12'h000, 16'h0080, 16'h0000);
      loopback_in <= 1'b1;
      frame_end(1'b1, 1'b0);
      loopback_in <= 1'b0;
      read_chk("loopback flag", 12'h000, 16'h0080, 16'h0000);
      frame_end(1'b0, 1'b1);
      apb(1'b1, 12'h000, 8'h00);
      frame_end(1'b1, 1'b0);
      read_chk("stamp cleared", 12'h008, 16'hFFFF, 16'h0000);
      // Initialization mode
      apb(1'b1, 12'h000, 8'h2D);
      read_chk("init ack", 12'h004, 16'h0002, 16'h0002);
      read_chk("init hold", 12'h000, 16'h00FF, 16'h0005);
      apb(1'b1, 12'h000, 8'h00);
      read_chk("init exit", 12'h004, 16'h0002, 16'h0000);
      apb(1'b1, 12'h000, 8'h28);
      read_chk("writable again", 12'h000, 16'h00EF, 16'h0028);
      // Wait mode with stop-in-wait set enters power-down
      engine_tx_bit <= 1'b0;
      cpu_wait_mode <= 1'b1;
      count_pulses(1'b0, 1'b1, 10);
      check("abort pulses", 32'(hits), 32'h1);
      check("clock gated", 32'(bus_clock_enable), 32'h0);
      check("tx recessive", 32'(bus_transmit_pin), 32'h1);
      apb(1'b0, 12'h000, 8'h00);
      check("power-down refuse", 32'(err), 32'h1);
      cpu_wait_mode <= 1'b0;
      engine_tx_bit <= 1'b1;
      apb(1'b1, 12'h000, 8'h00);
      cpu_wait_mode <= 1'b1;
      repeat (4) @(posedge pclk);
      #1 check("clock kept", 32'(bus_clock_enable), 32'h1);
      @(posedge pclk);
      cpu_wait_mode <= 1'b0;
      // Stop mode alone enters power-down
      cpu_stop_mode <= 1'b1;
      count_pulses(1'b0, 1'b1, 10);
      check("stop abort", 32'(hits), 32'h1);
      check("stop tx recessive", 32'(bus_transmit_pin), 32'h1);
      cpu_stop_mode <= 1'b0;
      // Sleep without wake-up
      rx_busy_in <= 1'b1;
      apb(1'b1, 12'h000, 8'h02);
      apb(1'b1, 12'h000, 8'h00);
      read_chk("early clear", 12'h000, 16'h0002, 16'h0002);
      read_chk("no ack busy", 12'h004, 16'h0001, 16'h0000);
      rx_busy_in <= 1'b0;
      wait_reg(12'h004, 8'h01, 8'h01);
      count_pulses(1'b1, 1'b0, 10);
      check("rx masked", 32'(can_rx_internal), 32'h1);
      repeat (30) @(posedge pclk);
      check("no wake", 32'(hits), 32'h0);
      read_chk("still asleep", 12'h004, 16'h0001, 16'h0001);
      apb(1'b1, 12'h000, 8'h00);
      wait_reg(12'h004, 8'h01, 8'h00);
      // Sleep with wake-up enabled, programmed first
      apb(1'b1, 12'h000, 8'h04);
      apb(1'b1, 12'h000, 8'h06);
      wait_reg(12'h004, 8'h01, 8'h01);
      count_pulses(1'b1, 1'b0, 40);
      check("wake pulses", 32'(hits), 32'h1);
      read_chk("awake", 12'h004, 16'h0001, 16'h0000);
      read_chk("not synched", 12'h000, 16'h0016, 16'h0004);
      repeat (11 * `BIT_CYCLES + 300) @(posedge pclk);
      read_chk("synched", 12'h000, 16'h0010, 16'h0010);
      test_done();
   end
endmodule : can_control_sleep_wakeup_test

`default_nettype wire
